/* File: adcc_top.sv */
// adcc_top: digital control of a 10-bit successive-approximation converter:
// register port, channel mux and pin override, clock select and divider,
// sequencer, result justification with read interlock, completion flag, irq.
// assumes the analog front end samples while sample_ff is high, compares the
// selected input with dac_code_ff and returns the answer on comparator_in.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module adcc_top
  import adcc_pkg::*;
#(
  parameter int RESULT_W = 10,
  parameter int NUM_PINS = 6
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_ff,
  input wire logic crystal_reference_clock,
  input wire logic comparator_in,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic [NUM_PINS-1:0] port_data_latch,
  input wire logic [NUM_PINS-1:0] port_direction,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out_ff,
  output logic [NUM_PINS-1:0] pin_oe_ff,
  output logic [NUM_PINS-1:0] port_read_ff,
  output logic [4:0] mux_select_ff,
  output logic conv_enable_ff,
  output logic sample_ff,
  output logic [RESULT_W-1:0] dac_code_ff,
  output logic conv_irq_ff
);

  generate
    if (RESULT_W != ADCC_RESULT_BITS || NUM_PINS < 1 || NUM_PINS > 6) begin : g_bad_param
      $error("adcc_top: RESULT_W must be 10 and NUM_PINS 1 to 6");
    end
  endgenerate

  // divide ratio per divider code; codes above the last double clamp to it
  function automatic logic [4:0] div_ratio(input logic [2:0] code);
    logic [2:0] c;
    c = (code > ADCC_DIV_MAX_CODE) ? ADCC_DIV_MAX_CODE : code;
    div_ratio = 5'h01 << c;
  endfunction

  function automatic logic [7:0] fmt_high(input adcc_just_t m, input logic [9:0] r);
    logic [7:0] v;
    v = 8'h00;
    unique case (m)
      ADCC_JUST_LEFT: v = r[9:2];
      ADCC_JUST_RIGHT: v = {6'h00, r[9:8]};
      ADCC_JUST_LEFT_SIGN: v = {~r[9], r[8:2]};
      ADCC_JUST_TRUNC: v = 8'h00;
    endcase
    fmt_high = v;
  endfunction

  function automatic logic [7:0] fmt_low(input adcc_just_t m, input logic [9:0] r);
    logic [7:0] v;
    v = 8'h00;
    unique case (m)
      ADCC_JUST_LEFT: v = {r[1:0], 6'h00};
      ADCC_JUST_RIGHT: v = r[7:0];
      ADCC_JUST_LEFT_SIGN: v = {r[1:0], 6'h00};
      ADCC_JUST_TRUNC: v = r[9:2];
    endcase
    fmt_low = v;
  endfunction

  adcc_status_t status_ff;
  adcc_clock_t clock_reg_ff;
  adcc_state_t state_ff;
  logic conversion_complete_flag_ff;
  logic [RESULT_W-1:0] result_ff;
  logic [RESULT_W-1:0] bit_ff;
  logic lock_ff;
  logic resume_ff;
  logic [4:0] prescale_ff;
  logic [3:0] cycle_ff;
  logic xtal_s1_ff, xtal_s2_ff, xtal_s3_ff;
  logic comp_s1_ff, comp_s2_ff;
  logic [NUM_PINS-1:0] pin_s1_ff, pin_s2_ff;

  adcc_just_t just_mode;
  logic wr_status, wr_clock, rd_high, rd_low;
  logic chan_on, start_req, src_tick, adc_tick, conv_done, store_ok;
  logic [RESULT_W-1:0] final_code;

  assign just_mode = adcc_just_t'({clock_reg_ff.justify_select_high,
                                   clock_reg_ff.justify_select_low});
  assign wr_status = bus_wr && (bus_addr == ADCC_OFF_STATUS);
  assign wr_clock = bus_wr && (bus_addr == ADCC_OFF_CLOCK);
  assign rd_high = bus_rd && (bus_addr == ADCC_OFF_RES_HIGH);
  assign rd_low = bus_rd && (bus_addr == ADCC_OFF_RES_LOW);
  assign chan_on = status_ff.channel_select_field != ADCC_CH_OFF;
  // a status write starts from the newly written channel
  assign start_req = wr_status && (bus_wdata[4:0] != ADCC_CH_OFF);

  // crystal clock and comparator come from outside: two flops first
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      xtal_s1_ff <= 1'b0;
      xtal_s2_ff <= 1'b0;
      xtal_s3_ff <= 1'b0;
      comp_s1_ff <= 1'b0;
      comp_s2_ff <= 1'b0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      xtal_s1_ff <= crystal_reference_clock;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
      comp_s1_ff <= comparator_in;
      comp_s2_ff <= comp_s1_ff;
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // crystal clock must stay below a quarter of the bus clock to be seen edge by edge
  assign src_tick = clock_reg_ff.conv_clock_source_select ?
                    (xtal_s2_ff && !xtal_s3_ff) : 1'b1;
  assign adc_tick = src_tick && (prescale_ff == div_ratio(clock_reg_ff.conv_clock_divider) - 5'h01);

  // the prescaler runs free so a start lands mid-cycle; that partial cycle
  // is the extra one on top of the sixteen counted ones
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prescale_ff <= 5'h00;
    end else if (adc_tick || wr_clock) begin
      prescale_ff <= 5'h00;
    end else if (src_tick) begin
      prescale_ff <= prescale_ff + 5'h01;
    end
  end

  // registers written by software
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // the live flag is conversion_complete_flag_ff; this bit of the copy is never read
      status_ff.conversion_complete_flag <= ADCC_STATUS_RESET.conversion_complete_flag;
      status_ff.conv_interrupt_enable <= ADCC_STATUS_RESET.conv_interrupt_enable;
      status_ff.continuous_convert_bit <= ADCC_STATUS_RESET.continuous_convert_bit;
      status_ff.channel_select_field <= ADCC_STATUS_RESET.channel_select_field;
      clock_reg_ff <= ADCC_CLOCK_RESET;
    end else begin
      if (wr_status) begin
        status_ff.conv_interrupt_enable <= bus_wdata[6];
        status_ff.continuous_convert_bit <= bus_wdata[5];
        status_ff.channel_select_field <= bus_wdata[4:0];
      end
      if (wr_clock) begin
        clock_reg_ff <= {bus_wdata[7:2], 2'b00};
      end
    end
  end
  // sequencer: sample, then one decision per converter cycle from the top bit
  assign final_code = comp_s2_ff ? dac_code_ff : (dac_code_ff & ~bit_ff);
  assign conv_done = (state_ff == ADCC_BITS) && adc_tick && bit_ff[0] && !stop_mode;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= ADCC_IDLE;
      cycle_ff <= 4'h0;
      bit_ff <= '0;
      dac_code_ff <= '0;
      sample_ff <= 1'b0;
    end else if (stop_mode) begin
      state_ff <= ADCC_IDLE;
      sample_ff <= 1'b0;
    end else if (start_req || (resume_ff && chan_on)) begin
      state_ff <= ADCC_SAMPLE;
      cycle_ff <= 4'h0;
      sample_ff <= 1'b1;
      dac_code_ff <= '0;
    end else if (adc_tick) begin
      unique case (state_ff)
        ADCC_IDLE: begin
          sample_ff <= 1'b0;
        end
        ADCC_SAMPLE: begin
          // the first tick after a start only closes the partial cycle, so
          // sixteen full ticks follow it and the total stays within 16 to 17
          if (cycle_ff == 4'(ADCC_SAMPLE_CYCLES)) begin
            state_ff <= ADCC_BITS;
            sample_ff <= 1'b0;
            bit_ff <= {1'b1, {(RESULT_W-1){1'b0}}};
            dac_code_ff <= {1'b1, {(RESULT_W-1){1'b0}}};
          end else begin
            cycle_ff <= cycle_ff + 4'h1;
          end
        end
        ADCC_BITS: begin
          // a comparator answer of 1 keeps the bit on trial, an answer of 0 drops it
          dac_code_ff <= final_code | (bit_ff >> 1);
          bit_ff <= bit_ff >> 1;
          if (bit_ff[0]) begin
            if (status_ff.continuous_convert_bit && chan_on) begin
              state_ff <= ADCC_SAMPLE;
              cycle_ff <= 4'h0;
              sample_ff <= 1'b1;
              dac_code_ff <= '0;
            end else begin
              state_ff <= ADCC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // stop remembers a running conversion and restarts it afterwards
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      resume_ff <= 1'b0;
    end else if (stop_mode) begin
      if (state_ff != ADCC_IDLE || start_req) begin
        resume_ff <= 1'b1;
      end
    end else begin
      resume_ff <= 1'b0;
    end
  end

  // results: outside ADCC_JUST_TRUNC, blocked while the high byte has been read and the low not yet
  assign store_ok = conv_done && !(lock_ff && just_mode != ADCC_JUST_TRUNC);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      result_ff <= '0;
    end else if (store_ok) begin
      result_ff <= final_code;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lock_ff <= 1'b0;
    end else if (rd_low || wr_status || just_mode == ADCC_JUST_TRUNC) begin
      lock_ff <= 1'b0;
    end else if (rd_high) begin
      lock_ff <= 1'b1;
    end
  end

  // completion flag and irq: a finishing conversion wins over a clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      conversion_complete_flag_ff <= 1'b0;
    end else if (conv_done && !status_ff.conv_interrupt_enable) begin
      conversion_complete_flag_ff <= 1'b1;
    end else if (wr_status || wr_clock || rd_low) begin
      conversion_complete_flag_ff <= 1'b0;
    end
  end

  // the irq is a level that stays up through wait so it can wake the core
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      conv_irq_ff <= 1'b0;
    end else if (conv_done && status_ff.conv_interrupt_enable) begin
      conv_irq_ff <= 1'b1;
    end else if (wr_status || rd_low || rd_high) begin
      conv_irq_ff <= 1'b0;
    end
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bus_rdata_ff <= 8'h00;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADCC_OFF_STATUS: begin
          bus_rdata_ff <= {conversion_complete_flag_ff && !status_ff.conv_interrupt_enable,
                           status_ff[6:0]};
        end
        ADCC_OFF_RES_HIGH: begin
          bus_rdata_ff <= fmt_high(just_mode, result_ff);
        end
        ADCC_OFF_RES_LOW: begin
          bus_rdata_ff <= fmt_low(just_mode, result_ff);
        end
        ADCC_OFF_CLOCK: begin
          bus_rdata_ff <= clock_reg_ff;
        end
        default: begin
          bus_rdata_ff <= 8'h00;
        end
      endcase
    end else begin
      bus_rdata_ff <= 8'h00;
    end
  end

  // analog mux select and converter power; wait_mode leaves both alone
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mux_select_ff <= ADCC_CH_OFF;
      conv_enable_ff <= 1'b0;
    end else begin
      mux_select_ff <= status_ff.channel_select_field;
      conv_enable_ff <= chan_on && !stop_mode && (wait_mode || !wait_mode);
    end
  end

  // shared pins: the selected one loses its driver, reads follow direction
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic selected;
      assign selected = chan_on && (status_ff.channel_select_field == 5'(gi));
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          pin_out_ff[gi] <= 1'b0;
          pin_oe_ff[gi] <= 1'b0;
          port_read_ff[gi] <= 1'b0;
        end else begin
          pin_out_ff[gi] <= port_data_latch[gi] && !selected;
          pin_oe_ff[gi] <= port_direction[gi] && !selected;
          port_read_ff[gi] <= port_direction[gi] ? port_data_latch[gi]
                                                 : pin_s2_ff[gi];
        end
      end
    end
  endgenerate

endmodule // adcc_top

`default_nettype wire

/* File: adcc_pkg.sv */
// adcc_pkg: register offsets, field layouts, reset values, channel and mode codes
// and cycle counts for the converter control block.
// assumes an 8-bit register port and a single bus clock.
package adcc_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADCC_OFF_STATUS = 8'h3c;
  localparam logic [7:0] ADCC_OFF_RES_HIGH = 8'h3d;
  localparam logic [7:0] ADCC_OFF_RES_LOW = 8'h3e;
  localparam logic [7:0] ADCC_OFF_CLOCK = 8'h3f;

  // conv_status_control_reg layout, bit 7 down to bit 0
  typedef struct packed {
    logic conversion_complete_flag;
    logic conv_interrupt_enable;
    logic continuous_convert_bit;
    logic [4:0] channel_select_field;
  } adcc_status_t;

  // conv_clock_reg layout, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] conv_clock_divider;
    logic conv_clock_source_select;
    logic justify_select_high;
    logic justify_select_low;
    logic [1:0] reserved;
  } adcc_clock_t;

  localparam adcc_status_t ADCC_STATUS_RESET = 8'h1f;
  localparam adcc_clock_t ADCC_CLOCK_RESET = 8'h00;

  // channel codes
  localparam logic [4:0] ADCC_CH_LAST_PIN = 5'h05;
  localparam logic [4:0] ADCC_CH_BANDGAP = 5'h06;
  localparam logic [4:0] ADCC_CH_REF_HIGH = 5'h1c;
  localparam logic [4:0] ADCC_CH_REF_LOW = 5'h1e;
  localparam logic [4:0] ADCC_CH_OFF = 5'h1f;

  // justification codes {justify_select_high, justify_select_low}
  typedef enum logic [1:0] {
    ADCC_JUST_LEFT = 2'b00,
    ADCC_JUST_RIGHT = 2'b01,
    ADCC_JUST_LEFT_SIGN = 2'b10,
    ADCC_JUST_TRUNC = 2'b11
  } adcc_just_t;

  // converter sequencer
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_SAMPLE = 2'b01,
    ADCC_BITS = 2'b10
  } adcc_state_t;

  // converter clock cycles per conversion: sampling, then one per result bit
  localparam int ADCC_CONV_CYCLES = 16;
  localparam int ADCC_RESULT_BITS = 10;
  localparam int ADCC_SAMPLE_CYCLES = ADCC_CONV_CYCLES - ADCC_RESULT_BITS;
  localparam logic [2:0] ADCC_DIV_MAX_CODE = 3'h4;

endpackage

/* File: adcc_assertions.sv */
// adcc_assertions: port-level checks of the converter control block.
// assumes it is bound to adcc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module adcc_assertions
  import adcc_pkg::*;
#(
  parameter int RESULT_W = 10,
  parameter int NUM_PINS = 6
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata_ff,
  input wire logic crystal_reference_clock,
  input wire logic comparator_in,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic [NUM_PINS-1:0] port_data_latch,
  input wire logic [NUM_PINS-1:0] port_direction,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out_ff,
  input wire logic [NUM_PINS-1:0] pin_oe_ff,
  input wire logic [NUM_PINS-1:0] port_read_ff,
  input wire logic [4:0] mux_select_ff,
  input wire logic conv_enable_ff,
  input wire logic sample_ff,
  input wire logic [RESULT_W-1:0] dac_code_ff,
  input wire logic conv_irq_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic st_wr;
  logic res_rd;
  assign st_wr = bus_wr && bus_addr == ADCC_OFF_STATUS;
  assign res_rd = bus_rd && (bus_addr == ADCC_OFF_RES_HIGH || bus_addr == ADCC_OFF_RES_LOW);

  sel_pin_input_a: assert property (
    $past(reset_n) && $stable(mux_select_ff) && int'(mux_select_ff) < NUM_PINS
    |-> pin_oe_ff[mux_select_ff] == 1'b0) else $error("selected pin is driven");
  port_latch_a: assert property (
    $past(reset_n) && &$past(port_direction) |-> port_read_ff == $past(port_data_latch))
    else $error("port read ignores data latch");
  mux_follow_a: assert property (
    st_wr ##1 (!bus_wr)[*2] |-> mux_select_ff == $past(bus_wdata[4:0], 2))
    else $error("mux does not follow channel field");
  start_sample_a: assert property (
    st_wr && bus_wdata[4:0] != ADCC_CH_OFF && !stop_mode |=> sample_ff)
    else $error("status write did not start sampling");
  conv_min_a: assert property (
    st_wr |=> (!conv_irq_ff)[*8]) else $error("completion too soon after start");
  irq_rd_clear_a: assert property (
    res_rd |=> !conv_irq_ff) else $error("irq not withdrawn by result read");
  stop_off_a: assert property (
    $past(reset_n) && $past(stop_mode) |-> !conv_enable_ff) else $error("converter on in stop");
  stop_quiet_a: assert property (
    stop_mode[*2] |-> !$rose(conv_irq_ff)) else $error("completion during stop");
endmodule // adcc_assertions

`default_nettype wire

/* File: testbench.sv */
// testbench: register-level tests of the converter control block.
// assumes the comparator answer is held constant so results are 3ff or 000.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import adcc_pkg::*;
;
  localparam int XT = 44;
  localparam logic [7:0] RD_OFFS [4] = '{8'h3d, 8'h3e, 8'h3f, 8'h50};
  logic clock, reset_n, bus_wr, bus_rd, crystal_reference_clock, comparator_in;
  logic stop_mode, wait_mode, conv_enable_ff, sample_ff, conv_irq_ff;
  logic [7:0] bus_addr, bus_wdata, bus_rdata_ff;
  logic [5:0] port_data_latch, port_direction, pin_in, pin_out_ff, pin_oe_ff, port_read_ff;
  logic [4:0] mux_select_ff;
  logic [9:0] dac_code_ff;
  int error_cnt = 0;
  int n_checks = 0;

  adcc_top #(.RESULT_W(10), .NUM_PINS(6)) adcc_top_i (
    .clock(clock), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_ff(bus_rdata_ff),
    .crystal_reference_clock(crystal_reference_clock), .comparator_in(comparator_in),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .port_data_latch(port_data_latch),
    .port_direction(port_direction), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
    .pin_oe_ff(pin_oe_ff), .port_read_ff(port_read_ff), .mux_select_ff(mux_select_ff),
    .conv_enable_ff(conv_enable_ff), .sample_ff(sample_ff), .dac_code_ff(dac_code_ff),
    .conv_irq_ff(conv_irq_ff));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // free-running and unrelated in phase to the bus clock
  initial begin
    crystal_reference_clock = 1'b0;
    #3.3;
    forever #22 crystal_reference_clock = ~crystal_reference_clock;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 v = bus_rdata_ff;
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (conv_irq_ff !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
  endtask

  task automatic wait_conversion_complete_flag(output logic [7:0] v);
    for (int i = 0; i < 60; i++) begin
      rd(ADCC_OFF_STATUS, v);
      if (v[7] === 1'b1) break;
    end
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: fmt = {r, 6'h00};
      2'h1: fmt = {6'h00, r};
      2'h2: fmt = {~r[9], r[8:0], 6'h00};
      default: fmt = {8'h00, r[9:2]};
    endcase
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    logic [7:0] d;
    logic [15:0] e;
    logic [1:0] m;
    int n, r, lo, hi;
    {reset_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    {comparator_in, stop_mode, wait_mode} = '0;
    {port_data_latch, port_direction, pin_in} = '0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(ADCC_OFF_STATUS, d); chk("status_reset", d, ADCC_STATUS_RESET);
    foreach (RD_OFFS[i]) begin
      rd(RD_OFFS[i], d); chk("reg_reset", d, 8'h00);
    end
    chk("mux_off", mux_select_ff, ADCC_CH_OFF);
    chk("conv_off", conv_enable_ff, 1'b0);
    wr(ADCC_OFF_CLOCK, 8'hff); rd(ADCC_OFF_CLOCK, d); chk("clock_rw", d, 8'hfc);
    wr(ADCC_OFF_RES_HIGH, 8'h55); rd(ADCC_OFF_RES_HIGH, d); chk("res_ro", d, 8'h00);
    $display("test registers done");

    port_direction <= 6'h3f; port_data_latch <= 6'h2a; pin_in <= 6'h15;
    wr(ADCC_OFF_STATUS, 8'h02);
    repeat (4) @(posedge clock);
    #1 chk("pin_oe", pin_oe_ff, 6'h3b);
    chk("pin_out", pin_out_ff & 6'h3b, 6'h2a);
    chk("port_read", port_read_ff, 6'h2a);
    chk("mux_sel", mux_select_ff, 5'h02);
    port_direction <= 6'h3b; port_data_latch <= 6'h3f;
    repeat (5) @(posedge clock);
    #1 chk("pin_oe_kept", pin_oe_ff, 6'h3b);
    chk("port_read_live", port_read_ff, 6'h3f);
    $display("test pins done");

    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      comparator_in <= i[0];
      wr(ADCC_OFF_CLOCK, {4'h0, m, 2'h0});
      wr(ADCC_OFF_STATUS, 8'h00);
      wait_conversion_complete_flag(d); chk("conversion_complete_flag_set", d[7], 1'b1);
      e = fmt(m, i[0] ? 10'h3ff : 10'h000);
      rd(ADCC_OFF_RES_HIGH, d); chk("res_high", d, e[15:8]);
      rd(ADCC_OFF_RES_LOW, d); chk("res_low", d, e[7:0]);
      repeat (30) @(posedge clock);
      rd(ADCC_OFF_STATUS, d); chk("one_shot", d, 8'h00);
    end
    wr(ADCC_OFF_STATUS, 8'h00);
    wait_conversion_complete_flag(d);
    wr(ADCC_OFF_CLOCK, 8'h00);
    rd(ADCC_OFF_STATUS, d); chk("conversion_complete_flag_clk_clear", d, 8'h00);
    $display("test formats done");

    for (int k = 0; k < 2; k++) begin
      m = k ? 2'h3 : 2'h0;
      comparator_in <= 1'b1;
      wr(ADCC_OFF_CLOCK, {4'h0, m, 2'h0});
      wr(ADCC_OFF_STATUS, 8'h20);
      repeat (25) @(posedge clock);
      rd(ADCC_OFF_RES_HIGH, d);
      comparator_in <= 1'b0;
      repeat (60) @(posedge clock);
      e = fmt(m, k ? 10'h000 : 10'h3ff);
      rd(ADCC_OFF_RES_LOW, d); chk("lock_low", d, e[7:0]);
      repeat (60) @(posedge clock);
      rd(ADCC_OFF_RES_HIGH, d); chk("cont_high", d, 8'h00);
      wr(ADCC_OFF_STATUS, 8'h1f);
    end
    $display("test continuous done");

    // wait mode held on: the converter must carry on regardless
    wait_mode <= 1'b1;
    comparator_in <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      r = (k == 8) ? 1 : (k > 4 ? 16 : 1 << k);
      wr(ADCC_OFF_CLOCK, k == 8 ? 8'h10 : {k[2:0], 5'h00});
      wr(ADCC_OFF_STATUS, 8'h40);
      wait_irq(n);
      lo = k == 8 ? 16 * XT / 5 - 2 : 16 * r;
      hi = k == 8 ? 17 * XT / 5 + 6 : 17 * r + 2;
      chk("conv_len", n >= lo && n <= hi, 1'b1);
      rd(ADCC_OFF_STATUS, d); chk("conversion_complete_flag_masked", d, 8'h40);
      rd(ADCC_OFF_RES_LOW, d); chk("irq_rd_clear", conv_irq_ff, 1'b0);
      chk("div_low", d, 8'hc0);
    end
    wait_mode <= 1'b0;
    $display("test divider done");

    wr(ADCC_OFF_CLOCK, 8'h00);
    wr(ADCC_OFF_STATUS, 8'h40);
    repeat (5) @(posedge clock);
    stop_mode <= 1'b1;
    repeat (40) @(posedge clock);
    #1 chk("stop_enable", conv_enable_ff, 1'b0);
    chk("stop_irq", conv_irq_ff, 1'b0);
    stop_mode <= 1'b0;
    // the resumed conversion doubles as the settling cycle after stop
    wait_irq(n); chk("resume", n >= 16 && n <= 22, 1'b1);
    wr(ADCC_OFF_STATUS, 8'h5f);
    #1 chk("irq_wr_clear", conv_irq_ff, 1'b0);
    $display("test stop done");
    summarize();
  end
endmodule // testbench

bind adcc_top adcc_assertions #(.RESULT_W(RESULT_W), .NUM_PINS(NUM_PINS)) adcc_assertions_i (
  .clock(clock), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_ff(bus_rdata_ff),
  .crystal_reference_clock(crystal_reference_clock), .comparator_in(comparator_in),
  .stop_mode(stop_mode), .wait_mode(wait_mode), .port_data_latch(port_data_latch),
  .port_direction(port_direction), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
  .pin_oe_ff(pin_oe_ff), .port_read_ff(port_read_ff), .mux_select_ff(mux_select_ff),
  .conv_enable_ff(conv_enable_ff), .sample_ff(sample_ff), .dac_code_ff(dac_code_ff),
  .conv_irq_ff(conv_irq_ff));

`default_nettype wire
